// ### bench/dfr_drive_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// ramp generator, brake and power stage seen as motor speed
// ------------------------------------------------------------
module dfr_drive_model (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // from the manager
  input  wire logic [15:0] speedSetpointOut,
  input  wire logic        pulseEnable,
  input  wire logic        brakeClose,
  // to the manager
  output logic      [15:0] speedActual
);
  logic [15:0] speed_q;
  logic [15:0] speed_d;
  // powered motor with open brake and a nonzero setpoint jumps to it; otherwise it decays, never overshoots
  always_comb begin
    speed_d = speed_q - (speed_q >> 2) - 16'(speed_q != 16'h0000);
    if (pulseEnable && !brakeClose && speedSetpointOut != 16'h0000) begin
      speed_d = speedSetpointOut;
    end
  end
  // speed register
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      speed_q <= 16'h0000;
    end else begin
      speed_q <= speed_d;
    end
  end
  assign speedActual = speed_q;
endmodule : dfr_drive_model
`default_nettype wire

// ### bench/dfr_reaction_manager_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// port checker for the fault reaction manager
// ------------------------------------------------------------
module dfr_reaction_manager_sva #(
  parameter int unsigned NF       = 8,
  parameter int unsigned NA       = 8,
  parameter int unsigned TICK_CYC = 4
) (
  // clock and reset
  input wire logic          mclk,
  input wire logic          rstn,
  // causes and requests
  input wire logic [NF-1:0] faultCause,
  input wire logic [NA-1:0] alarmCause,
  input wire logic [7:0]    control_mode_select,
  input wire logic          holding_brake_config,
  input wire logic          switchOnRequest,
  // results
  input wire logic [15:0]   drive_status_word_1,
  input wire logic          faultLogValid,
  input wire logic [15:0]   delayed_stop_remaining,
  input wire logic [15:0]   speedSetpointOut,
  input wire logic          rampActive,
  input wire logic          brakeClose,
  input wire logic          pulseEnable,
  input wire logic          switchOnInhibit,
  input wire logic          switchOnGranted,
  input wire logic [NF-1:0] faultLogMask,
  input wire logic          alarmLogValid,
  input wire logic [NA-1:0] alarmLogMask,
  input wire logic          traverseAbort,
  input wire logic          trackingMode
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // two sync stages plus the status register give exactly three edges
  fault_flag_a: assert property (
    $rose(|faultCause) |-> ##3 drive_status_word_1[3]
  ) else $error("fault flag late");
  log_flag_a: assert property (
    faultLogValid |-> drive_status_word_1[3]
  ) else $error("fault logged without flag");
  alarm_set_a: assert property (
    (|alarmCause)[*4] |-> drive_status_word_1[7]
  ) else $error("alarm flag missing");
  alarm_clear_a: assert property (
    (alarmCause == '0)[*4] |-> !drive_status_word_1[7]
  ) else $error("alarm flag stuck");
  grant_gate_a: assert property (
    switchOnGranted == (switchOnRequest && !switchOnInhibit)
  ) else $error("switch-on grant wrong");
  // inhibit only arrives together with dead pulses and the brake
  coast_stop_a: assert property (
    $rose(switchOnInhibit) |-> !pulseEnable &&
      brakeClose == holding_brake_config
  ) else $error("coast stop incomplete");
  ramp_zero_a: assert property (
    rampActive && control_mode_select < 8'h16 && control_mode_select > 8'h13
      |-> speedSetpointOut == 16'h0000
  ) else $error("setpoint not forced");
  inhibit_hold_a: assert property (
    switchOnInhibit && drive_status_word_1[3] |=> switchOnInhibit
  ) else $error("inhibit dropped early");
  remain_down_a: assert property (
    delayed_stop_remaining != 16'h0000 |-> pulseEnable ##1
      delayed_stop_remaining <= $past(delayed_stop_remaining)
  ) else $error("delay count wrong");
  log_mask_a: assert property (
    faultLogValid == (faultLogMask != '0)
  ) else $error("fault log mask wrong");
  alarm_log_a: assert property (
    alarmLogValid |-> drive_status_word_1[7] && alarmLogMask != '0
  ) else $error("alarm log entry wrong");
  abort_pulse_a: assert property (
    traverseAbort |-> trackingMode ##1 !traverseAbort
  ) else $error("traverse abort wrong");
  cover property ($rose(trackingMode));
  cover property ($rose(switchOnInhibit));
  cover property ($fell(pulseEnable) && !switchOnInhibit);
  cover property (delayed_stop_remaining != 16'h0000);
endmodule : dfr_reaction_manager_sva

bind dfr_reaction_manager dfr_reaction_manager_sva #(
  .NF(NF), .NA(NA), .TICK_CYC(TICK_CYC)
) i_dfr_reaction_manager_sva (
  .mclk, .rstn, .faultCause, .alarmCause, .control_mode_select,
  .holding_brake_config, .switchOnRequest, .drive_status_word_1,
  .faultLogValid, .delayed_stop_remaining, .speedSetpointOut, .rampActive,
  .brakeClose, .pulseEnable, .switchOnInhibit, .switchOnGranted,
  .faultLogMask, .alarmLogValid, .alarmLogMask, .traverseAbort, .trackingMode
);
`default_nettype wire

// ### bench/test_dfr_reaction_manager.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// self-checking bench for the fault reaction manager
// ------------------------------------------------------------
module test_dfr_reaction_manager;
  logic        mclk, rstn, fault_ack_request, holding_brake_config;
  logic        torque_control_changeover, positioner_active_flag;
  logic        inhibitClear, switchOnRequest, faultLogValid, alarmLogValid;
  logic        rampActive, brakeClose, pulseEnable, switchOnInhibit;
  logic        switchOnGranted, traverseAbort, trackingMode;
  logic [7:0]  faultCause, alarmCause, control_mode_select;
  logic [7:0]  faultLogMask, alarmLogMask;
  logic [15:0] faultReaction, ramp_down_time, speedSetpointIn, speedActual;
  logic [15:0] drive_status_word_1, delayed_stop_remaining;
  logic [15:0] speedSetpointOut, rampTimeOut;
  logic [15:0] brakeTime, monitorTime, delayTime;
  int          n_fail, n_tests, k;

  // one timebase tick is four cycles, so every stop finishes quickly
  dfr_reaction_manager #(.NF(8), .NA(8), .TICK_CYC(4)) i_dfr_reaction_manager (
    .mclk, .rstn, .faultCause, .faultReaction, .alarmCause,
    .fault_ack_request, .control_mode_select, .torque_control_changeover,
    .holding_brake_config, .positioner_active_flag,
    .brake_application_time(brakeTime), .standstill_monitor_time(monitorTime),
    .delayed_stop_time(delayTime), .ramp_down_time,
    .standstill_speed_threshold(16'h0010), .speedActual, .speedSetpointIn,
    .inhibitClear, .switchOnRequest, .drive_status_word_1, .faultLogValid,
    .faultLogMask, .alarmLogValid, .alarmLogMask, .delayed_stop_remaining,
    .speedSetpointOut, .rampTimeOut, .rampActive, .brakeClose, .pulseEnable,
    .switchOnInhibit, .switchOnGranted, .traverseAbort, .trackingMode);
  dfr_drive_model i_dfr_drive_model (
    .mclk, .rstn, .speedSetpointOut, .pulseEnable, .brakeClose, .speedActual);

  // 125 MHz clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wrap_up;
    $display("tests=%0d fails=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  // bounded wait for the pulse state, sampled away from the edge
  task automatic waitPulse(input logic v);
    for (k = 0; k < 800 && pulseEnable !== v; k++) @(negedge mclk);
    if (k == 800) begin
      n_fail++;
      $display("FAIL t=%0t pulse=%h exp=%h", $time, pulseEnable, v);
      wrap_up();
    end
    tick(1);
  endtask : waitPulse

  // pulse state two cycles after the latch
  function automatic logic expPulse(logic [1:0] r, logic [7:0] m, logic c);
    return r < dfr_pkg::REACT_RAMP || (r == dfr_pkg::REACT_RAMP &&
      (m < dfr_pkg::MODE_TORQUE_A || c));
  endfunction : expPulse

  // a no-reaction run adds a coast fault later to test precedence
  task automatic run(input logic [1:0] r, input logic [7:0] m);
    int          i;
    logic [15:0] fr;
    logic        inh;
    i = $urandom % 8;
    fr = 16'($urandom);
    fr[2*i +: 2] = r;
    fr[2*((i+1)%8) +: 2] = dfr_pkg::REACT_COAST;
    faultReaction <= fr;
    brakeTime <= 16'($urandom % 5);
    monitorTime <= 16'(1 + $urandom % 8);
    delayTime <= 16'(1 + $urandom % 6);
    positioner_active_flag <= r == dfr_pkg::REACT_NONE;
    ramp_down_time <= 16'($urandom);
    switchOnRequest <= 1'($urandom);
    speedSetpointIn <= (m > dfr_pkg::MODE_SPEED_B) ? 16'h0005 :
      16'h0100 + 16'($urandom % 256);
    tick(4);
    // changeover was driven in the calling time step, so read it only now
    inh = r == dfr_pkg::REACT_COAST || (r == dfr_pkg::REACT_RAMP &&
      m > dfr_pkg::MODE_SPEED_B && !torque_control_changeover);
    faultCause[i] <= 1'b1;
    tick(5);
    @(negedge mclk);
    chk(drive_status_word_1, 16'h0008);
    chk(pulseEnable, expPulse(r, m, torque_control_changeover));
    chk(switchOnInhibit, inh);
    if (inh) chk(brakeClose, holding_brake_config);
    if (r == dfr_pkg::REACT_NONE) chk(trackingMode, 1'b1);
    if (r == dfr_pkg::REACT_DELAYED) chk(pulseEnable &&
      delayed_stop_remaining != 16'h0000, 1'b1);
    if (r == dfr_pkg::REACT_RAMP && m < dfr_pkg::MODE_TORQUE_A) begin
      chk(speedSetpointOut | 16'(!rampActive), 16'h0000);
      chk(rampTimeOut, ramp_down_time);
    end
    tick(1);
    if (r == dfr_pkg::REACT_NONE) faultCause[(i+1)%8] <= 1'b1;
    waitPulse(1'b0);
    @(negedge mclk);
    chk(brakeClose, holding_brake_config);
    tick(1);
    fault_ack_request <= 1'b1;
    tick(6);
    fault_ack_request <= 1'b0;
    faultCause <= 8'h00;
    tick(6);
    @(negedge mclk);
    chk(drive_status_word_1[3], 1'b1);
    tick(1);
    fault_ack_request <= 1'b1;
    tick(6);
    @(negedge mclk);
    chk(drive_status_word_1[3], 1'b0);
    chk(trackingMode, 1'b0);
    tick(1);
    fault_ack_request <= 1'b0;
    inhibitClear <= 1'b1;
    tick(1);
    inhibitClear <= 1'b0;
    waitPulse(1'b1);
  endtask : run

  // main sequence: reset, alarms, then every reaction in every mode
  initial begin
    n_fail = 0;
    n_tests = 0;
    k = $urandom(32'hDF92326E);
    {rstn, fault_ack_request, holding_brake_config, inhibitClear} = 4'h0;
    {torque_control_changeover, positioner_active_flag} = 2'h0;
    {switchOnRequest, faultCause, alarmCause, control_mode_select} = 25'h0;
    {faultReaction, ramp_down_time, speedSetpointIn} = 48'h0;
    {brakeTime, monitorTime, delayTime} = 48'h0;
    tick(20);
    rstn <= 1'b1;
    tick(3);
    @(negedge mclk);
    chk(pulseEnable, 1'b1);
    for (int a = 0; a < 3; a++) begin
      tick(1);
      alarmCause <= 8'h01 << ($urandom % 8);
      tick(5);
      @(negedge mclk);
      chk(drive_status_word_1, 16'h0080);
      tick(1);
      alarmCause <= 8'h00;
      tick(5);
      @(negedge mclk);
      chk(drive_status_word_1, 16'h0000);
    end
    tick(1);
    for (int r = 0; r < 4; r++) begin
      for (int m = 0; m < 4; m++) begin
        control_mode_select <= dfr_pkg::MODE_SPEED_A + 8'(m);
        torque_control_changeover <= 1'($urandom);
        holding_brake_config <= 1'($urandom);
        run(2'(r), dfr_pkg::MODE_SPEED_A + 8'(m));
      end
    end
    wrap_up();
  end
endmodule : test_dfr_reaction_manager
`default_nettype wire

// ### hdl/dfr_pkg.sv
`default_nettype none
package dfr_pkg;

  // -------------------------------------------------------------------------
  // status word bit positions
  // -------------------------------------------------------------------------
  localparam int unsigned FAULT_BIT = 3;
  localparam int unsigned ALARM_BIT = 7;

  // -------------------------------------------------------------------------
  // control modes
  // -------------------------------------------------------------------------
  localparam logic [7:0] MODE_SPEED_A  = 8'h14;
  localparam logic [7:0] MODE_SPEED_B  = 8'h15;
  localparam logic [7:0] MODE_TORQUE_A = 8'h16;
  localparam logic [7:0] MODE_TORQUE_B = 8'h17;

  // -------------------------------------------------------------------------
  // reaction codes, ordered by rising severity
  // -------------------------------------------------------------------------
  localparam logic [1:0] REACT_NONE    = 2'h0;
  localparam logic [1:0] REACT_DELAYED = 2'h1;
  localparam logic [1:0] REACT_RAMP    = 2'h2;
  localparam logic [1:0] REACT_COAST   = 2'h3;

  // -------------------------------------------------------------------------
  // reset values and timing
  // -------------------------------------------------------------------------
  localparam logic [15:0] STATUS_RST = 16'h0000;
  localparam int unsigned CLK_MHZ    = 125;
  localparam int unsigned TICK_US    = 1000;
  localparam int unsigned TICK_CYC   = CLK_MHZ * TICK_US;

  typedef enum logic [2:0] {
    ST_RUN, ST_DELAY, ST_RAMP, ST_BRAKE, ST_OFF
  } stop_type;

endpackage : dfr_pkg
`default_nettype wire

// ### hdl/dfr_reaction_manager.sv
// What this block does
// - fault starts reaction, sets bit 3, logs
// - fault latched until cause gone and acked
// - alarm sets bit 7 and logs entry
// - alarm clears itself when cause leaves
// - no-reaction fault never stops the drive
// - positioner active: abort task, hold tracking
// - speed mode ramp stop zeroes setpoint, ramps
// - zero speed closes brake, then pulses off
// - zero speed by threshold or monitor timer
// - torque mode ramp stop acts as coast
// - changeover torque: no braking, brake, pulses
// - delayed stop waits, publishes remaining time
// - coast stop removes pulse enable at once
// - coast stop closes brake at once
// - coast stop sets switch-on inhibit
// - acknowledge on rising edge of request
`timescale 1ns/1ps
`default_nettype none
module dfr_reaction_manager #(
  parameter int unsigned NF       = 8,
  parameter int unsigned NA       = 8,
  parameter int unsigned TICK_CYC = dfr_pkg::TICK_CYC
) (
  // clock and reset
  input  wire  logic            mclk,
  input  wire  logic            rstn,
  // detectors and configuration
  input  wire  logic [NF-1:0]   faultCause,
  input  wire  logic [2*NF-1:0] faultReaction,
  input  wire  logic [NA-1:0]   alarmCause,
  input  wire  logic            fault_ack_request,
  input  wire  logic [7:0]      control_mode_select,
  input  wire  logic            torque_control_changeover,
  input  wire  logic            holding_brake_config,
  input  wire  logic            positioner_active_flag,
  input  wire  logic [15:0]     brake_application_time,
  input  wire  logic [15:0]     standstill_monitor_time,
  input  wire  logic [15:0]     delayed_stop_time,
  input  wire  logic [15:0]     ramp_down_time,
  input  wire  logic [15:0]     standstill_speed_threshold,
  input  wire  logic [15:0]     speedActual,
  input  wire  logic [15:0]     speedSetpointIn,
  input  wire  logic            inhibitClear,
  input  wire  logic            switchOnRequest,
  // status and logging
  output logic [15:0]           drive_status_word_1,
  output logic                  faultLogValid,
  output logic [NF-1:0]         faultLogMask,
  output logic                  alarmLogValid,
  output logic [NA-1:0]         alarmLogMask,
  output logic [15:0]           delayed_stop_remaining,
  // actuation
  output logic [15:0]           speedSetpointOut,
  output logic [15:0]           rampTimeOut,
  output logic                  rampActive,
  output logic                  brakeClose,
  output logic                  pulseEnable,
  output logic                  switchOnInhibit,
  output logic                  switchOnGranted,
  output logic                  traverseAbort,
  output logic                  trackingMode
);

  // -------------------------------------------------------------------------
  // input synchronisers
  // -------------------------------------------------------------------------
  logic [NF-1:0] fS1_q, fS2_q;
  logic [NA-1:0] aS1_q, aS2_q;
  logic          kS1_q, kS2_q, kS3_q;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      fS1_q <= '0; fS2_q <= '0; aS1_q <= '0; aS2_q <= '0;
      kS1_q <= 1'b0; kS2_q <= 1'b0; kS3_q <= 1'b0;
    end else begin
      fS1_q <= faultCause; fS2_q <= fS1_q;
      aS1_q <= alarmCause; aS2_q <= aS1_q;
      kS1_q <= fault_ack_request; kS2_q <= kS1_q; kS3_q <= kS2_q;
    end
  end
  logic ackEdge;
  assign ackEdge = kS2_q & ~kS3_q;

  // -------------------------------------------------------------------------
  // millisecond tick divider
  // -------------------------------------------------------------------------
  logic [31:0] div_q, div_d;
  logic        tick;
  assign tick = (div_q == 32'(TICK_CYC - 1));
  always_comb begin
    div_d = tick ? 32'h0000_0000 : div_q + 32'h0000_0001;
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) div_q <= 32'h0000_0000;
    else       div_q <= div_d;
  end

  // -------------------------------------------------------------------------
  // fault latches and alarm tracking
  // -------------------------------------------------------------------------
  logic [NF-1:0] faultLat_q, faultLat_d, newFault;
  logic [NA-1:0] alarm_q, alarm_d, newAlarm;
  logic [1:0]    worst;
  logic          anyNone;
  always_comb begin
    newFault   = fS2_q & ~faultLat_q;
    faultLat_d = faultLat_q | fS2_q;
    // set wins: a live cause keeps its latch through an acknowledge
    if (ackEdge) faultLat_d = fS2_q;
    alarm_d  = aS2_q;
    newAlarm = aS2_q & ~alarm_q;
    worst    = dfr_pkg::REACT_NONE;
    anyNone  = 1'b0;
    for (int i = 0; i < NF; i++) begin
      if (faultLat_q[i] && faultReaction[2*i +: 2] > worst)
        worst = faultReaction[2*i +: 2];
      if (faultLat_q[i] && faultReaction[2*i +: 2] == dfr_pkg::REACT_NONE)
        anyNone = 1'b1;
    end
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      faultLat_q <= '0;
      alarm_q    <= '0;
    end else begin
      faultLat_q <= faultLat_d;
      alarm_q    <= alarm_d;
    end
  end

  // -------------------------------------------------------------------------
  // stop sequencer
  // -------------------------------------------------------------------------
  dfr_pkg::stop_type st_q, st_d;
  logic [15:0] tmr_q, tmr_d, mon_q, mon_d;
  logic        inh_q, inh_d, brk_q, brk_d, pul_q, pul_d;
  logic        torqueMode, zeroSpeed, setLow, anyFault;
  assign torqueMode = (control_mode_select == dfr_pkg::MODE_TORQUE_A) ||
                      (control_mode_select == dfr_pkg::MODE_TORQUE_B);
  assign setLow     = speedSetpointIn <= standstill_speed_threshold;
  assign zeroSpeed  = (speedActual < standstill_speed_threshold) ||
                      (setLow && mon_q == 16'h0000);
  assign anyFault   = |faultLat_q;

  always_comb begin
    st_d  = st_q;
    tmr_d = tmr_q;
    inh_d = inh_q;
    brk_d = brk_q;
    pul_d = pul_q;
    mon_d = mon_q;
    // monitor timer runs only while the setpoint sits at or below threshold
    if (!setLow) mon_d = standstill_monitor_time;
    else if (tick && mon_q != 16'h0000) mon_d = mon_q - 16'h0001;
    if (inhibitClear && !anyFault) inh_d = 1'b0;
    unique case (st_q)
      dfr_pkg::ST_RUN: begin
        brk_d = 1'b0;
        pul_d = 1'b1;
        // no-reaction faults leave the sequencer here
        if (worst == dfr_pkg::REACT_COAST ||
            (worst == dfr_pkg::REACT_RAMP && torqueMode &&
             !torque_control_changeover)) begin
          st_d = dfr_pkg::ST_OFF;
          pul_d = 1'b0;
          brk_d = holding_brake_config;
          inh_d = 1'b1;
        end else if (worst == dfr_pkg::REACT_RAMP) begin
          st_d = dfr_pkg::ST_RAMP;
        end else if (worst == dfr_pkg::REACT_DELAYED) begin
          st_d  = dfr_pkg::ST_DELAY;
          tmr_d = delayed_stop_time;
        end
      end
      dfr_pkg::ST_DELAY: begin
        if (worst == dfr_pkg::REACT_COAST || worst == dfr_pkg::REACT_RAMP ||
            worst == dfr_pkg::REACT_NONE && !anyFault)
          st_d = dfr_pkg::ST_RUN;
        else if (tmr_q == 16'h0000 && torqueMode &&
                 !torque_control_changeover) begin
          // a late ramp stop in plain torque control is a coast stop
          st_d  = dfr_pkg::ST_OFF;
          pul_d = 1'b0;
          brk_d = holding_brake_config;
          inh_d = 1'b1;
        end else if (tmr_q == 16'h0000)
          st_d = dfr_pkg::ST_RAMP;
        else if (tick)
          tmr_d = tmr_q - 16'h0001;
      end
      dfr_pkg::ST_RAMP: begin
        if (worst == dfr_pkg::REACT_COAST) begin
          st_d = dfr_pkg::ST_RUN;
        end else if (zeroSpeed) begin
          st_d  = dfr_pkg::ST_BRAKE;
          brk_d = holding_brake_config;
          tmr_d = brake_application_time;
        end
      end
      dfr_pkg::ST_BRAKE: begin
        // a coast fault during brake timing still wins
        if (worst == dfr_pkg::REACT_COAST) begin
          st_d = dfr_pkg::ST_RUN;
        end else if (tmr_q == 16'h0000) begin
          st_d  = dfr_pkg::ST_OFF;
          pul_d = 1'b0;
        end else if (tick) begin
          tmr_d = tmr_q - 16'h0001;
        end
      end
      dfr_pkg::ST_OFF: begin
        pul_d = 1'b0;
        // a coast fault arriving after a ramp stop still locks switch-on
        if (worst == dfr_pkg::REACT_COAST) begin
          brk_d = holding_brake_config;
          inh_d = 1'b1;
        end
        if (!anyFault && !inh_q) st_d = dfr_pkg::ST_RUN;
      end
      default: st_d = dfr_pkg::ST_RUN;
    endcase
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_q  <= dfr_pkg::ST_RUN;
      tmr_q <= 16'h0000;
      mon_q <= 16'h0000;
      inh_q <= 1'b0;
      brk_q <= 1'b0;
      pul_q <= 1'b0;
    end else begin
      st_q  <= st_d;
      tmr_q <= tmr_d;
      mon_q <= mon_d;
      inh_q <= inh_d;
      brk_q <= brk_d;
      pul_q <= pul_d;
    end
  end

  // -------------------------------------------------------------------------
  // registered outputs, plus the combinational switch-on grant
  // -------------------------------------------------------------------------
  logic ramping, trk_q, trk_d;
  assign ramping = (st_q == dfr_pkg::ST_RAMP) && !torqueMode;
  always_comb begin
    trk_d = trk_q;
    if (positioner_active_flag && anyNone) trk_d = 1'b1;
    else if (!anyFault) trk_d = 1'b0;
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      trk_q                  <= 1'b0;
      drive_status_word_1    <= dfr_pkg::STATUS_RST;
      faultLogValid          <= 1'b0;
      faultLogMask           <= '0;
      alarmLogValid          <= 1'b0;
      alarmLogMask           <= '0;
      delayed_stop_remaining <= 16'h0000;
      speedSetpointOut       <= 16'h0000;
      rampTimeOut            <= 16'h0000;
      rampActive             <= 1'b0;
      traverseAbort          <= 1'b0;
    end else begin
      trk_q <= trk_d;
      drive_status_word_1 <= STATUS_BITS();
      faultLogValid <= |newFault;
      faultLogMask  <= newFault;
      alarmLogValid <= |newAlarm;
      alarmLogMask  <= newAlarm;
      delayed_stop_remaining <= (st_q == dfr_pkg::ST_DELAY) ? tmr_q
                                                            : 16'h0000;
      speedSetpointOut <= ramping ? 16'h0000 : speedSetpointIn;
      rampTimeOut      <= ramp_down_time;
      rampActive       <= ramping;
      traverseAbort    <= trk_d & ~trk_q;
    end
  end

  function automatic logic [15:0] STATUS_BITS();
    logic [15:0] w;
    w = dfr_pkg::STATUS_RST;
    w[dfr_pkg::FAULT_BIT] = |faultLat_d;
    w[dfr_pkg::ALARM_BIT] = |alarm_d;
    return w;
  endfunction : STATUS_BITS

  assign brakeClose      = brk_q;
  assign pulseEnable     = pul_q;
  assign switchOnInhibit = inh_q;
  assign switchOnGranted = switchOnRequest & ~inh_q;
  assign trackingMode    = trk_q;

endmodule : dfr_reaction_manager
`default_nettype wire
